//--- src/tsca_core.sv
// Configuration, conversion sequencing and alert logic of a temperature sensor.
// Assumes a register port decoded from the serial interface and a converter code
// that is valid, on the same clock, whenever a conversion ends.
`timescale 1ns/1ns
`default_nettype none
module tsca_core #(
  parameter int CONV_9_CYCLES  = tsca_pkg::CONV_9_CYC,
  parameter int CONV_10_CYCLES = tsca_pkg::CONV_10_CYC,
  parameter int CONV_11_CYCLES = tsca_pkg::CONV_11_CYC,
  parameter int CONV_12_CYCLES = tsca_pkg::CONV_12_CYC
) (
  input  wire logic                         i_clock,
  input  wire logic                         i_nrst,
  input  wire logic [tsca_pkg::PTR_W-1:0]   i_reg_sel,
  input  wire logic                         i_wr_strobe,
  input  wire logic [15:0]                  i_wr_data,
  input  wire logic                         i_rd_strobe,
  input  wire logic [tsca_pkg::CODE_W-1:0]  i_adc_code,
  output logic      [15:0]                  o_rd_data,
  output logic                              o_alert,
  output logic                              o_sampling,
  output logic                              o_conv_done
);
  import tsca_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tsca_state_t           state_reg;
  tsca_state_t           state_next;
  logic [7:0]            cfg_reg;
  logic [15:0]           temp_reg;
  logic [15:0]           upper_reg;
  logic [15:0]           hyst_reg;
  logic [CONV_CNT_W-1:0] conv_cnt_reg;
  logic [CONV_CNT_W-1:0] conv_limit;
  logic [CODE_W-1:0]     res_mask;
  logic [CODE_W-1:0]     sample;
  logic [FQ_W-1:0]       fq_needed;
  logic                  conv_end;
  logic                  cfg_wr;
  logic                  one_shot_go;
  logic                  entering_shut;
  logic                  mode_change;
  logic                  over_cond;
  logic                  under_cond;
  logic                  over_q;
  logic                  under_q;
  logic                  active_reg;
  logic                  phase_reg;
  logic                  int_set;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  assign cfg_wr = i_wr_strobe && (i_reg_sel == PTR_CONFIG);

  // single conversion accepted only from shutdown.
  assign one_shot_go = cfg_wr && i_wr_data[CFG_ONESHOT_BIT] && i_wr_data[CFG_SHUT_BIT]
                       && (state_reg == ST_SHUT);

  assign entering_shut = (state_reg == ST_RUN) && cfg_reg[CFG_SHUT_BIT];
  assign mode_change   = cfg_wr && (i_wr_data[CFG_INT_BIT] != cfg_reg[CFG_INT_BIT]);

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= i_wr_data[7:0];
      // request with shutdown only kept from shutdown.
      cfg_reg[CFG_ONESHOT_BIT] <= i_wr_data[CFG_ONESHOT_BIT]
                                  && (!i_wr_data[CFG_SHUT_BIT] || (state_reg == ST_SHUT));
    end else if ((state_reg == ST_ONE) && conv_end) begin
      cfg_reg[CFG_ONESHOT_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      upper_reg <= UPPER_RESET;
      hyst_reg  <= HYST_RESET;
    end else if (i_wr_strobe) begin
      // only the nine top bits are kept.
      if (i_reg_sel == PTR_UPPER) begin
        upper_reg <= i_wr_data & LIMIT_MASK;
      end
      if (i_reg_sel == PTR_HYST) begin
        hyst_reg <= i_wr_data & LIMIT_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // every register readable in any state.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_strobe) begin
      case (i_reg_sel)
        PTR_TEMP:   o_rd_data <= temp_reg;
        PTR_CONFIG: o_rd_data <= {8'h00, cfg_reg};
        PTR_HYST:   o_rd_data <= hyst_reg;
        PTR_UPPER:  o_rd_data <= upper_reg;
        default:    o_rd_data <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUT: begin
        if (one_shot_go) begin
          state_next = ST_ONE;
        end else if (!cfg_reg[CFG_SHUT_BIT]) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cfg_reg[CFG_SHUT_BIT]) begin
          state_next = ST_SHUT;
        end
      end
      ST_ONE: begin
        if (conv_end) begin
          state_next = cfg_reg[CFG_SHUT_BIT] ? ST_SHUT : ST_RUN;
        end
      end
      default: state_next = ST_SHUT;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_SHUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  // duration follows the resolution.
  always_comb begin
    case (cfg_reg[CFG_RES_MSB:CFG_RES_LSB])
      RES_9:   conv_limit = CONV_CNT_W'(CONV_9_CYCLES);
      RES_10:  conv_limit = CONV_CNT_W'(CONV_10_CYCLES);
      RES_11:  conv_limit = CONV_CNT_W'(CONV_11_CYCLES);
      default: conv_limit = CONV_CNT_W'(CONV_12_CYCLES);
    endcase
  end

  assign conv_end = (state_reg != ST_SHUT) && (conv_cnt_reg >= conv_limit - CONV_CNT_W'(1));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_cnt_reg <= '0;
    end else if ((state_reg == ST_SHUT) || conv_end) begin
      conv_cnt_reg <= '0;
    end else begin
      conv_cnt_reg <= conv_cnt_reg + CONV_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sampling  <= 1'b0;
      o_conv_done <= 1'b0;
    end else begin
      o_sampling  <= (state_next != ST_SHUT);
      o_conv_done <= conv_end;
    end
  end

  // ----------------------------------------------------------------
  // Measured temperature
  // ----------------------------------------------------------------
  // resolution picks the kept code bits.
  always_comb begin
    case (cfg_reg[CFG_RES_MSB:CFG_RES_LSB])
      RES_9:   res_mask = RES_MASK_9;
      RES_10:  res_mask = RES_MASK_10;
      RES_11:  res_mask = RES_MASK_11;
      default: res_mask = RES_MASK_12;
    endcase
  end

  // unused fraction bits forced to zero.
  assign sample = i_adc_code & res_mask;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      temp_reg <= TEMP_RESET;
    end else if (conv_end) begin
      temp_reg <= {sample, TEMP_PAD};
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison and fault queues
  // ----------------------------------------------------------------
  // signed compare on aligned scale.
  assign over_cond  = $signed(sample) > $signed({upper_reg[15:LIMIT_LSB], LIMIT_PAD});
  assign under_cond = $signed(sample) < $signed({hyst_reg[15:LIMIT_LSB], LIMIT_PAD});

  always_comb begin
    case (cfg_reg[CFG_FQ_MSB:CFG_FQ_LSB])
      FQ_1C:   fq_needed = FQ_N1;
      FQ_2C:   fq_needed = FQ_N2;
      FQ_4C:   fq_needed = FQ_N4;
      default: fq_needed = FQ_N6;
    endcase
  end

  tsca_fault_queue #(
    .W (FQ_W)
  ) u_over_queue (
    .i_clock        (i_clock),
    .i_nrst         (i_nrst),
    .i_sample_valid (conv_end),
    .i_condition    (over_cond),
    .i_needed       (fq_needed),
    .o_qualified    (over_q)
  );

  tsca_fault_queue #(
    .W (FQ_W)
  ) u_under_queue (
    .i_clock        (i_clock),
    .i_nrst         (i_nrst),
    .i_sample_valid (conv_end),
    .i_condition    (under_cond),
    .i_needed       (fq_needed),
    .o_qualified    (under_q)
  );

  // ----------------------------------------------------------------
  // Alert state
  // ----------------------------------------------------------------
  assign int_set = phase_reg ? under_q : over_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      active_reg <= 1'b0;
      phase_reg  <= 1'b0;
    end else if (mode_change) begin
      // A qualified over-limit sample in the same cycle still raises the alert.
      active_reg <= over_q;
      phase_reg  <= over_q && i_wr_data[CFG_INT_BIT];
    end else if (cfg_reg[CFG_INT_BIT]) begin
      if (int_set) begin
        // interrupt on crossing the upper limit, then on falling below the hysteresis limit.
        active_reg <= 1'b1;
        phase_reg  <= ~phase_reg;
      end else if (entering_shut) begin
        active_reg <= 1'b0;
      end else if (i_rd_strobe) begin
        active_reg <= 1'b0;
      end
    end else begin
      if (over_q) begin
        active_reg <= 1'b1;
      end else if (under_q && (state_reg == ST_RUN)) begin
        active_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_alert <= 1'b1;
    end else begin
      o_alert <= cfg_reg[CFG_POL_BIT] ? active_reg : ~active_reg;
    end
  end

endmodule
`default_nettype wire

//--- shared/tsca_pkg.sv
// Constants, register map and state codes of the temperature sensor control block.
// Assumes a 50 MHz system clock and a converter that hands over a 12-bit code.
package tsca_pkg;

  // ----------------------------------------------------------------
  // Clock and conversion timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ   = 50_000_000;
  localparam int CYC_PER_MS = CLOCK_HZ / 1000;
  localparam int CONV_9_MS  = 30;
  localparam int CONV_10_MS = 60;
  localparam int CONV_11_MS = 120;
  localparam int CONV_12_MS = 240;
  localparam int CONV_9_CYC  = CONV_9_MS * CYC_PER_MS;
  localparam int CONV_10_CYC = CONV_10_MS * CYC_PER_MS;
  localparam int CONV_11_CYC = CONV_11_MS * CYC_PER_MS;
  localparam int CONV_12_CYC = CONV_12_MS * CYC_PER_MS;
  localparam int CONV_CNT_W  = 24;

  // ----------------------------------------------------------------
  // Register pointer codes
  // ----------------------------------------------------------------
  localparam int         PTR_W      = 2;
  localparam logic [1:0] PTR_TEMP   = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_HYST   = 2'h2;
  localparam logic [1:0] PTR_UPPER  = 2'h3;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_ONESHOT_BIT = 7;
  localparam int CFG_RES_MSB     = 6;
  localparam int CFG_RES_LSB     = 5;
  localparam int CFG_FQ_MSB      = 4;
  localparam int CFG_FQ_LSB      = 3;
  localparam int CFG_POL_BIT     = 2;
  localparam int CFG_INT_BIT     = 1;
  localparam int CFG_SHUT_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [15:0] TEMP_RESET  = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'hA000;
  localparam logic [15:0] HYST_RESET  = 16'h9600;

  // ----------------------------------------------------------------
  // Data layout
  // ----------------------------------------------------------------
  localparam int          CODE_W     = 12;
  localparam int          LIMIT_LSB  = 7;
  localparam logic [15:0] LIMIT_MASK = 16'hFF80;
  localparam logic [3:0]  TEMP_PAD   = 4'h0;
  localparam logic [2:0]  LIMIT_PAD  = 3'h0;

  // ----------------------------------------------------------------
  // Resolution codes and masks
  // ----------------------------------------------------------------
  localparam logic [1:0]  RES_9      = 2'h0;
  localparam logic [1:0]  RES_10     = 2'h1;
  localparam logic [1:0]  RES_11     = 2'h2;
  localparam logic [11:0] RES_MASK_9  = 12'hFF8;
  localparam logic [11:0] RES_MASK_10 = 12'hFFC;
  localparam logic [11:0] RES_MASK_11 = 12'hFFE;
  localparam logic [11:0] RES_MASK_12 = 12'hFFF;

  // ----------------------------------------------------------------
  // Fault queue depths
  // ----------------------------------------------------------------
  localparam int         FQ_W  = 3;
  localparam logic [1:0] FQ_1C = 2'h0;
  localparam logic [1:0] FQ_2C = 2'h1;
  localparam logic [1:0] FQ_4C = 2'h2;
  localparam logic [2:0] FQ_N1 = 3'h1;
  localparam logic [2:0] FQ_N2 = 3'h2;
  localparam logic [2:0] FQ_N4 = 3'h4;
  localparam logic [2:0] FQ_N6 = 3'h6;

  // ----------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SHUT = 3'b001,
    ST_RUN  = 3'b010,
    ST_ONE  = 3'b100
  } tsca_state_t;

endpackage

//--- src/tsca_fault_queue.sv
// Consecutive-sample filter for one limit condition.
// Assumes the sample strobe and condition come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tsca_fault_queue #(
  parameter int W = 3
) (
  input  wire logic         i_clock,
  input  wire logic         i_nrst,
  input  wire logic         i_sample_valid,
  input  wire logic         i_condition,
  input  wire logic [W-1:0] i_needed,
  output logic              o_qualified
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // ----------------------------------------------------------------
  // Run length of the condition
  // ----------------------------------------------------------------
  always_comb begin
    count_next = '0;
    if (i_condition) begin
      if (count_reg >= i_needed) begin
        count_next = count_reg;
      end else begin
        count_next = count_reg + W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= '0;
    end else if (i_sample_valid) begin
      count_reg <= count_next;
    end
  end

  // The sample that completes the run qualifies in its own cycle.
  assign o_qualified = i_sample_valid && i_condition && (count_next >= i_needed);

endmodule
`default_nettype wire

//--- bench/tsca_properties.sv
// Concurrent checks on the ports of the sensor control core.
// Assumes it is bound to tsca_core; alert mode and polarity are shadowed from host writes.
`timescale 1ns/1ns
`default_nettype none
module tsca_properties #(
  parameter int CONV_9_CYCLES  = 20,
  parameter int CONV_10_CYCLES = 40,
  parameter int CONV_11_CYCLES = 80,
  parameter int CONV_12_CYCLES = 160
) (
  input wire logic                        i_clock,
  input wire logic                        i_nrst,
  input wire logic [tsca_pkg::PTR_W-1:0]  i_reg_sel,
  input wire logic                        i_wr_strobe,
  input wire logic [15:0]                 i_wr_data,
  input wire logic                        i_rd_strobe,
  input wire logic [tsca_pkg::CODE_W-1:0] i_adc_code,
  input wire logic [15:0]                 o_rd_data,
  input wire logic                        o_alert,
  input wire logic                        o_sampling,
  input wire logic                        o_conv_done
);
  import tsca_pkg::*;
  logic [1:0] sh_reg;
  logic       cfg_wr;
  logic       shut_wr;
  assign cfg_wr  = i_wr_strobe && (i_reg_sel == PTR_CONFIG);
  assign shut_wr = cfg_wr && i_wr_data[0] && !i_wr_data[7];

  // Shadow of polarity and alert mode.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_reg <= 2'h0;
    end else if (cfg_wr) begin
      sh_reg <= i_wr_data[2:1];
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  chk_cfg_read_back: assert property (
    i_rd_strobe && i_reg_sel == PTR_CONFIG |=> o_rd_data[15:8] == 8'h00 && o_rd_data[2:1] == $past(sh_reg))
    else $error("config read mismatch");
  chk_read_data_hold: assert property (
    !i_rd_strobe |=> $stable(o_rd_data)) else $error("read data moved without read");
  chk_limit_low_zero: assert property (
    i_rd_strobe && i_reg_sel[1] |=> o_rd_data[6:0] == 7'h00) else $error("limit low bits not zero");
  chk_temp_pad_zero: assert property (
    i_rd_strobe && i_reg_sel == PTR_TEMP |=> o_rd_data[3:0] == 4'h0) else $error("temperature pad not zero");
  chk_done_single_pulse: assert property (
    o_conv_done |=> !o_conv_done [*8]) else $error("conversions too close");
  chk_shut_no_sample: assert property (
    !o_sampling [*3] |-> !o_conv_done) else $error("conversion while stopped");
  chk_alert_has_cause: assert property (
    $changed(o_alert) |-> $past(o_conv_done) || $past(i_rd_strobe, 2) || $past(i_wr_strobe)
      || $past(i_wr_strobe, 2) || $past(i_wr_strobe, 3) || $past(i_wr_strobe, 4))
    else $error("alert moved without cause");
  chk_intr_read_clear: assert property (
    sh_reg[0] && i_rd_strobe && !i_wr_strobe ##1 !o_conv_done && !i_wr_strobe |=> o_alert == !sh_reg[1])
    else $error("read did not clear alert");
  chk_intr_shut_clear: assert property (
    sh_reg[0] && o_sampling && shut_wr && i_wr_data[1] |-> ##[2:5] o_alert == !sh_reg[1])
    else $error("shutdown did not clear alert");
endmodule
`default_nettype wire

//--- bench/tsca_host_model.sv
// Host model driving the register port with one-cycle strobes.
// Assumes the core samples strobes on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tsca_host_model (
  input  wire logic                       i_clock,
  input  wire logic [15:0]                i_rd_data,
  output logic      [tsca_pkg::PTR_W-1:0] o_reg_sel,
  output logic                            o_wr_strobe,
  output logic      [15:0]                o_wr_data,
  output logic                            o_rd_strobe
);
  import tsca_pkg::*;
  initial begin
    o_reg_sel   = 2'h0;
    o_wr_strobe = 1'b0;
    o_wr_data   = 16'h0000;
    o_rd_strobe = 1'b0;
  end

  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    @(posedge i_clock);
    o_reg_sel   <= sel;
    o_wr_data   <= data;
    o_wr_strobe <= 1'b1;
    @(posedge i_clock);
    o_wr_strobe <= 1'b0;
    o_wr_data   <= ~data;
  endtask

  task automatic rd(input logic [1:0] sel, output logic [15:0] data);
    @(posedge i_clock);
    o_reg_sel   <= sel;
    o_rd_strobe <= 1'b1;
    @(posedge i_clock);
    o_rd_strobe <= 1'b0;
    #1 data = i_rd_data;
  endtask

  task automatic one_shot(input logic [7:0] base);
    wr(PTR_CONFIG, {8'h00, base | 8'h01});
    repeat (3) @(posedge i_clock);
    wr(PTR_CONFIG, {8'h00, base | 8'h81});
  endtask
endmodule
`default_nettype wire

//--- bench/test_temp_sensor_config_alert.sv
// Self-checking bench for the sensor control core with a host model.
// Assumes shortened conversion lengths so each conversion takes 20 to 160 cycles.
`timescale 1ns/1ns
`default_nettype none
module test_temp_sensor_config_alert;
  import tsca_pkg::*;
  localparam int N9 = 20;
  logic        i_clock, i_nrst, i_wr_strobe, i_rd_strobe, o_alert, o_sampling, o_conv_done;
  logic [1:0]  i_reg_sel;
  logic [15:0] i_wr_data, o_rd_data, rdv, wd;
  logic [11:0] i_adc_code, code;
  logic [15:0] rst_tab [4] = '{16'h0000, 16'h0000, 16'h9600, 16'hA000};
  int          qn [4] = '{1, 2, 4, 6};
  int          err_total, checks_done, dones, n;

  tsca_core #(.CONV_9_CYCLES(N9), .CONV_10_CYCLES(2 * N9), .CONV_11_CYCLES(4 * N9),
              .CONV_12_CYCLES(8 * N9)) u_dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_sel(i_reg_sel), .i_wr_strobe(i_wr_strobe),
    .i_wr_data(i_wr_data), .i_rd_strobe(i_rd_strobe), .i_adc_code(i_adc_code), .o_rd_data(o_rd_data),
    .o_alert(o_alert), .o_sampling(o_sampling), .o_conv_done(o_conv_done));
  tsca_host_model u_host (
    .i_clock(i_clock), .i_rd_data(o_rd_data), .o_reg_sel(i_reg_sel), .o_wr_strobe(i_wr_strobe),
    .o_wr_data(i_wr_data), .o_rd_strobe(i_rd_strobe));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_conv_done === 1'b1) dones++;

  function automatic logic [15:0] exp_temp(input logic [11:0] c, input logic [1:0] r);
    logic [11:0] m;
    m = 12'hFFF << (3 - r);
    return {c & m, 4'h0};
  endfunction
  function automatic logic [15:0] lvl(input logic pol, input logic on);
    return {15'h0, on ? pol : ~pol};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_done(output int cyc);
    cyc = 0;
    do begin
      @(posedge i_clock);
      #1 cyc++;
    end while (o_conv_done !== 1'b1 && cyc < 400);
    if (cyc >= 400) begin
      err_total++;
      $display("ERROR conversion end expected pulse seen none");
      wrap_up();
    end
  endtask
  task automatic set_code(input logic [11:0] c);
    @(posedge i_clock);
    i_adc_code <= c;
  endtask
  task automatic settle(input logic [11:0] c);
    set_code(c);
    wait_done(n);
    wait_done(n);
    @(posedge i_clock);
    #1;
  endtask

  initial begin
    void'($urandom(28611));
    i_nrst = 1'b0;
    i_adc_code = 12'h000;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge i_clock);
    #1 chk("alert in reset", 16'h1, {15'h0, o_alert});
    chk("sampling in reset", 16'h0, {15'h0, o_sampling});
    @(posedge i_clock);
    i_nrst <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      u_host.rd(s[1:0], rdv);
      chk("reset value", rst_tab[s], rdv);
    end
    for (int i = 0; i < 6; i++) begin
      wd = 16'($urandom);
      u_host.wr({1'b1, i[0]}, wd);
      u_host.rd({1'b1, i[0]}, rdv);
      chk("limit", wd & 16'hFF80, rdv);
    end
    u_host.wr(PTR_TEMP, 16'hFFF0);
    u_host.rd(PTR_TEMP, rdv);
    chk("temperature write ignored", 16'h0000, rdv);
    u_host.wr(PTR_UPPER, 16'h1900);
    u_host.wr(PTR_HYST, 16'h1400);
    for (int r = 0; r < 4; r++) begin
      set_code(12'($urandom));
      u_host.wr(PTR_CONFIG, {9'h0, r[1:0], 5'h0});
      wait_done(n);
      wait_done(n);
      chk("conversion length", 16'(N9 << r), 16'(n));
      u_host.rd(PTR_TEMP, rdv);
      chk("temperature", exp_temp(i_adc_code, r[1:0]), rdv);
    end
    for (int q = 0; q < 4; q++) begin
      set_code(12'hF00);
      u_host.wr(PTR_CONFIG, {11'h0, q[1:0], q[0], 2'h0});
      for (int k = 0; k < 6; k++) wait_done(n);
      chk("alert idle", lvl(q[0], 1'b0), {15'h0, o_alert});
      set_code(12'h1A0);
      for (int k = 1; k <= qn[q]; k++) begin
        wait_done(n);
        @(posedge i_clock);
        #1 chk("alert over", lvl(q[0], k == qn[q]), {15'h0, o_alert});
      end
      set_code(12'hF00);
      for (int k = 1; k <= qn[q]; k++) begin
        wait_done(n);
        @(posedge i_clock);
        #1 chk("alert under", lvl(q[0], k != qn[q]), {15'h0, o_alert});
      end
    end
    u_host.wr(PTR_CONFIG, 16'h0000);
    settle(12'h1A0);
    u_host.wr(PTR_CONFIG, 16'h0001);
    set_code(12'hF00);
    repeat (3 * N9) @(posedge i_clock);
    #1 chk("comparator held in shutdown", 16'h0, {15'h0, o_alert});
    u_host.wr(PTR_CONFIG, 16'h0081);
    repeat (N9 + 8) @(posedge i_clock);
    #1 chk("comparator held after single", 16'h0, {15'h0, o_alert});
    u_host.wr(PTR_CONFIG, 16'h0002);
    settle(12'h1A0);
    chk("interrupt set", 16'h0, {15'h0, o_alert});
    u_host.rd(PTR_TEMP, rdv);
    @(posedge i_clock);
    #1 chk("interrupt read clear", 16'h1, {15'h0, o_alert});
    wait_done(n);
    @(posedge i_clock);
    #1 chk("interrupt stays clear", 16'h1, {15'h0, o_alert});
    settle(12'hF00);
    chk("interrupt under", 16'h0, {15'h0, o_alert});
    u_host.rd(PTR_CONFIG, rdv);
    @(posedge i_clock);
    #1 chk("interrupt under clear", 16'h1, {15'h0, o_alert});
    settle(12'h1A0);
    chk("interrupt set again", 16'h0, {15'h0, o_alert});
    u_host.wr(PTR_CONFIG, 16'h0003);
    repeat (5) @(posedge i_clock);
    #1 chk("shutdown clears alert", 16'h1, {15'h0, o_alert});
    chk("sampling stopped", 16'h0, {15'h0, o_sampling});
    u_host.wr(PTR_UPPER, 16'h1234);
    u_host.rd(PTR_UPPER, rdv);
    chk("upper in shutdown", 16'h1200, rdv);
    n = dones;
    repeat (3 * N9) @(posedge i_clock);
    chk("no conversion in shutdown", 16'(n), 16'(dones));
    code = 12'($urandom);
    set_code(code);
    n = dones;
    u_host.one_shot(8'h00);
    repeat (N9 + 8) @(posedge i_clock);
    #1 chk("single conversion count", 16'(n + 1), 16'(dones));
    u_host.rd(PTR_CONFIG, rdv);
    chk("request cleared", 16'h0001, rdv);
    u_host.rd(PTR_TEMP, rdv);
    chk("single result", exp_temp(code, 2'h0), rdv);
    repeat (2 * N9) @(posedge i_clock);
    chk("back to shutdown", 16'(n + 1), 16'(dones));
    u_host.wr(PTR_CONFIG, 16'h0080);
    n = dones;
    repeat (2 * N9 + 8) @(posedge i_clock);
    #1 chk("ignored request runs", 16'h1, {15'h0, o_sampling});
    chk("continuous conversions", 16'(n + 2), 16'(dones));
    u_host.wr(PTR_CONFIG, 16'h0081);
    u_host.rd(PTR_CONFIG, rdv);
    chk("request while running", 16'h0001, rdv);
    wrap_up();
  end
endmodule

bind tsca_core tsca_properties #(
  .CONV_9_CYCLES(CONV_9_CYCLES), .CONV_10_CYCLES(CONV_10_CYCLES),
  .CONV_11_CYCLES(CONV_11_CYCLES), .CONV_12_CYCLES(CONV_12_CYCLES)
) u_props (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_sel(i_reg_sel), .i_wr_strobe(i_wr_strobe),
  .i_wr_data(i_wr_data), .i_rd_strobe(i_rd_strobe), .i_adc_code(i_adc_code), .o_rd_data(o_rd_data),
  .o_alert(o_alert), .o_sampling(o_sampling), .o_conv_done(o_conv_done));
`default_nettype wire
